// [verilog/fifo_wm_top.v]
// sensor sample queue with watermark, depth cap and slope compression
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "fifo_wm_regs.vh"

// Summary of operation
// - eight-bit watermark level counted in words
// - watermark flag when count reaches level
// - stop bit makes watermark the queue depth
// - without stop bit fill to physical full
// - queue mode stops at capped depth, flags
// - continuous capped mode overwrites oldest word
// - compress only with both enables set
// - pack one, two or three by slope
// - five distinct tags per sensor
// - plain first word, then triple/double/plain
// - previous-slot tag only on flush
// - compression delays writes two batch periods
// - samples coded as difference from previous
// - runtime disable writes marker, then flushes
// - config change: marker, flush, resume compressing
// - periodic plain word every 8/16/32 events
// - axis value is low plus high<<8
// - nine-bit word count across two registers
module fifo_wm_top
(
    input wire clk,
    input wire arst_n,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire acc_valid,
    input wire [47:0] acc_sample,
    input wire gyr_valid,
    input wire [47:0] gyr_sample,
    input wire cfg_change,
    output reg watermark_flag,
    output reg full_flag
);

    // ------
    // registers and state
    // ------
    reg [7:0] watermark_level; // queue_control_one
    reg [4:0] queue_control_two; // stop, runtime enable, refresh period, continuous
    reg compression_enable; // embedded_function_enable_reg
    reg reinit; // one-cycle engine restart
    reg [7:0] wr_ptr; // next free entry
    reg [7:0] rd_ptr; // oldest entry
    reg [8:0] count; // words held
    reg [55:0] out_word; // word under the output registers
    reg mark_pend; // marker owed at next batch event
    reg flush_acc; // accel flush owed
    reg flush_gyr; // gyro flush owed
    reg [8:0] next_count;
    reg [7:0] next_rd;
    reg do_write;
    reg [55:0] wr_word;
    reg [7:0] rmux;

    wire stop_at_watermark = queue_control_two[`QC2_STOP];
    wire runtime_compression_enable = queue_control_two[`QC2_RTEN];
    wire [1:0] plain_refresh_period = queue_control_two[`QC2_RATE_HI:`QC2_RATE_LO];
    wire continuous = queue_control_two[`QC2_CONT];
    wire active = compression_enable && runtime_compression_enable;
    wire batch = acc_valid || gyr_valid;
    wire mark_now = mark_pend && batch;
    wire [8:0] depth = stop_at_watermark ? {1'b0, watermark_level} : `PHYS_DEPTH;
    wire pop = rd && (addr == `OUT_TAG_ADDR);
    wire has_word = (count != 9'h000);
    wire acc_wv;
    wire gyr_wv;
    wire [55:0] acc_word;
    wire [55:0] gyr_word;
    wire [55:0] head_word;
    wire acc_rdy = !mark_now;
    wire gyr_rdy = !mark_now && !acc_wv;
    wire ctl_wr = wr && (addr == `QC2_ADDR);

    // byte of a word: tag at 0, then x low, x high, y low, ...
    function [7:0] word_byte;
        input [55:0] w;
        input [7:0] a;
        begin
            if (a == `OUT_TAG_ADDR)
            begin
                word_byte = w[55:48];
            end
            else
            begin
                word_byte = w[(a - `OUT_DATA_BASE) * 8 +: 8];
            end
        end
    endfunction

    // ------
    // compression engines and storage
    // ------
    comp_engine #(.TAG_BASE(`TAG_ACC_BASE)) u_acc
    (
        .clk(clk),
        .arst_n(arst_n),
        .sample_valid(acc_valid),
        .sample(acc_sample),
        .active(active),
        .flush(flush_acc),
        .reinit(reinit),
        .refresh_period(plain_refresh_period),
        .word_ready(acc_rdy),
        .word_valid(acc_wv),
        .word(acc_word)
    );

    comp_engine #(.TAG_BASE(`TAG_GYR_BASE)) u_gyr
    (
        .clk(clk),
        .arst_n(arst_n),
        .sample_valid(gyr_valid),
        .sample(gyr_sample),
        .active(active),
        .flush(flush_gyr),
        .reinit(reinit),
        .refresh_period(plain_refresh_period),
        .word_ready(gyr_rdy),
        .word_valid(gyr_wv),
        .word(gyr_word)
    );

    word_store u_store
    (
        .clk(clk),
        .wr_en(do_write),
        .wr_addr(wr_ptr),
        .wr_word(wr_word),
        .rd_addr(rd_ptr),
        .rd_word(head_word)
    );

    // ------
    // write selection and occupancy
    // ------
    // marker first, then accel, then gyro; pop before push in the same cycle
    always @*
    begin
        wr_word = {`TAG_CFG, 48'h0};
        if (mark_now)
        begin
            wr_word = {`TAG_CFG, 48'h0};
        end
        else if (acc_wv)
        begin
            wr_word = acc_word;
        end
        else if (gyr_wv)
        begin
            wr_word = gyr_word;
        end
        next_count = count;
        next_rd = rd_ptr;
        if (pop && has_word)
        begin
            next_count = count - 9'h001;
            next_rd = rd_ptr + 8'h01;
        end
        do_write = 1'b0;
        if (mark_now || acc_wv || gyr_wv)
        begin
            if (next_count < depth)
            begin
                do_write = 1'b1;
                next_count = next_count + 9'h001;
            end
            else if (continuous && depth != 9'h000)
            begin
                do_write = 1'b1; // drop the oldest word
                next_rd = next_rd + 8'h01;
            end
        end
    end

    // pointers, count and flags
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr <= 8'h00;
            rd_ptr <= 8'h00;
            count <= 9'h000;
            full_flag <= 1'b0;
            watermark_flag <= 1'b0;
        end
        else
        begin
            if (do_write)
            begin
                // ring of 256 entries; the count alone caps the depth
                wr_ptr <= wr_ptr + 8'h01;
            end
            rd_ptr <= next_rd;
            count <= next_count;
            // full when a write fills the depth or finds it full
            if ((mark_now || acc_wv || gyr_wv) && next_count >= depth)
            begin
                full_flag <= 1'b1;
            end
            else if (next_count < depth)
            begin
                full_flag <= 1'b0;
            end
            watermark_flag <= (next_count >= {1'b0, watermark_level});
        end
    end

    // ------
    // flush bookkeeping
    // ------
    // a new request wins over the clear of the same cycle
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mark_pend <= 1'b0;
            flush_acc <= 1'b0;
            flush_gyr <= 1'b0;
        end
        else
        begin
            if ((cfg_change && active) || (ctl_wr && runtime_compression_enable
                && !wdata[`QC2_RTEN]))
            begin
                mark_pend <= 1'b1;
                flush_acc <= 1'b1;
                flush_gyr <= 1'b1;
            end
            else
            begin
                if (batch)
                begin
                    mark_pend <= 1'b0;
                end
                if (acc_valid)
                begin
                    flush_acc <= 1'b0;
                end
                if (gyr_valid)
                begin
                    flush_gyr <= 1'b0;
                end
            end
        end
    end

    // ------
    // register writes
    // ------
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            watermark_level <= `WTM_RST;
            queue_control_two <= `QC2_RST;
            compression_enable <= `EFE_RST;
            reinit <= 1'b0;
        end
        else
        begin
            reinit <= wr && (addr == `EFI_ADDR) && wdata[`EFI_REINIT];
            if (wr && addr == `QC1_ADDR)
            begin
                watermark_level <= wdata;
            end
            if (ctl_wr)
            begin
                queue_control_two <= wdata[4:0];
            end
            if (wr && addr == `EFE_ADDR)
            begin
                compression_enable <= wdata[`EFE_COMPR];
            end
        end
    end

    // ------
    // register reads
    // ------
    always @*
    begin
        case (addr)
            `QC1_ADDR: rmux = watermark_level;
            `QC2_ADDR: rmux = {3'b000, queue_control_two};
            `QS1_ADDR: rmux = count[7:0];
            `QS2_ADDR: rmux = {watermark_flag, full_flag, 5'b00000, count[8]};
            `EFE_ADDR: rmux = {7'h00, compression_enable};
            `OUT_TAG_ADDR: rmux = has_word ? head_word[55:48] : `TAG_EMPTY;
            default:
            begin
                if (addr > `OUT_TAG_ADDR && addr <= `OUT_DATA_LAST)
                begin
                    rmux = word_byte(out_word, addr);
                end
                else
                begin
                    rmux = 8'h00;
                end
            end
        endcase
    end

    // read data one cycle after the strobe; tag read latches the word
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata <= 8'h00;
            out_word <= 56'h0;
        end
        else
        begin
            if (rd)
            begin
                rdata <= rmux;
            end
            else
            begin
                rdata <= 8'h00;
            end
            if (pop)
            begin
                out_word <= has_word ? head_word : {`TAG_EMPTY, 48'h0};
            end
        end
    end

endmodule // fifo_wm_top

// [verilog/fifo_wm_regs.vh]
// register map and word tags of the sample queue
`ifndef FIFO_WM_REGS_VH
`define FIFO_WM_REGS_VH

// ------
// register offsets
// ------
`define QC1_ADDR 8'h00
`define QC2_ADDR 8'h01
`define QS1_ADDR 8'h02
`define QS2_ADDR 8'h03
`define OUT_TAG_ADDR 8'h04
`define OUT_DATA_BASE 8'h05
`define OUT_DATA_LAST 8'h0a
`define EFE_ADDR 8'h0b
`define EFI_ADDR 8'h0c

// ------
// field positions
// ------
`define QC2_STOP 0
`define QC2_RTEN 1
`define QC2_RATE_LO 2
`define QC2_RATE_HI 3
`define QC2_CONT 4
`define QS2_CNT8 0
`define QS2_FULL 6
`define QS2_WTM 7
`define EFE_COMPR 0
`define EFI_REINIT 0

// ------
// reset values
// ------
`define WTM_RST 8'h00
`define QC2_RST 5'h00
`define EFE_RST 1'b0

// ------
// word tags and packing limits
// ------
`define TAG_EMPTY 8'h00
`define TAG_CFG 8'h10
`define TAG_ACC_BASE 8'h01
`define TAG_GYR_BASE 8'h09
`define TOFF_NC 8'h00
`define TOFF_NCT2 8'h01
`define TOFF_NCT1 8'h02
`define TOFF_DBL 8'h03
`define TOFF_TRP 8'h04
`define LIM_TRIPLE 16'h0010
`define LIM_DOUBLE 16'h0080
`define PHYS_DEPTH 9'h100

`endif

// [verilog/word_store.v]
// word memory of the sample queue
`timescale 1ns/1ps
module word_store
(
    input wire clk,
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [55:0] wr_word,
    input wire [7:0] rd_addr,
    output wire [55:0] rd_word
);

    // one 7-byte word per entry: tag plus six data bytes
    reg [55:0] mem [0:255];

    // ------
    // write port
    // ------
    // no reset: contents are only read behind a valid count
    always @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_word;
        end
    end

    // oldest word, seen at once by the pop logic
    assign rd_word = mem[rd_addr];

endmodule // word_store

// [verilog/comp_engine.v]
// slope compression of one three-axis sensor stream into queue words
`timescale 1ns/1ps
`include "fifo_wm_regs.vh"
module comp_engine
#(
    parameter [7:0] TAG_BASE = `TAG_ACC_BASE
)
(
    input wire clk,
    input wire arst_n,
    input wire sample_valid,
    input wire [47:0] sample,
    input wire active,
    input wire flush,
    input wire reinit,
    input wire [1:0] refresh_period,
    input wire word_ready,
    output wire word_valid,
    output wire [55:0] word
);

    reg [47:0] ref_val; // last value the reader will have decoded
    reg [47:0] h0; // oldest pending sample
    reg [47:0] h1; // younger pending sample
    reg [1:0] pc; // number of pending samples
    reg fresh; // next event starts a new sequence
    reg [4:0] rcnt; // events since the last plain word
    reg [55:0] q [0:2]; // words waiting to leave
    reg [1:0] qn; // number of words waiting
    integer k;

    // true when every axis difference b-a lies strictly inside +-lim
    function fits;
        input [47:0] a;
        input [47:0] b;
        input [15:0] lim;
        reg [15:0] d;
        integer i;
        begin
            fits = 1'b1;
            for (i = 0; i < 3; i = i + 1)
            begin
                d = b[i*16 +: 16] - a[i*16 +: 16];
                if (d[15] ? (16'h0000 - d) >= lim : d >= lim)
                begin
                    fits = 1'b0;
                end
            end
        end
    endfunction

    // per-axis difference b-a cut to n low bits, packed z,y,x
    function [23:0] pack;
        input [47:0] a;
        input [47:0] b;
        input integer n;
        reg [15:0] d;
        integer i;
        begin
            pack = 24'h000000;
            for (i = 0; i < 3; i = i + 1)
            begin
                d = b[i*16 +: 16] - a[i*16 +: 16];
                pack = pack | ({8'h00, d & ((16'h0001 << n) - 16'h0001)} << (i * n));
            end
        end
    endfunction

    wire [4:0] rlimit = (refresh_period == 2'b01) ? 5'd7 :
        (refresh_period == 2'b10) ? 5'd15 : 5'd31;
    wire due = (refresh_period != 2'b00) && (rcnt >= rlimit);
    wire trp_ok = fits(ref_val, h0, `LIM_TRIPLE) && fits(h0, h1, `LIM_TRIPLE)
        && fits(h1, sample, `LIM_TRIPLE);
    wire dbl_ok = fits(ref_val, h0, `LIM_DOUBLE) && fits(h0, h1, `LIM_DOUBLE);

    // triple diffs of slots i, i-1, i-2, cut apart by the word layout
    wire [23:0] d5a = pack(h1, sample, 5);
    wire [23:0] d5b = pack(h0, h1, 5);
    wire [23:0] d5c = pack(ref_val, h0, 5);

    assign word_valid = (qn != 2'd0);
    assign word = q[0];

    // ------
    // window, reference and output queue
    // ------
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ref_val <= 48'h0;
            h0 <= 48'h0;
            h1 <= 48'h0;
            pc <= 2'd0;
            fresh <= 1'b1;
            rcnt <= 5'd0;
            qn <= 2'd0;
            for (k = 0; k < 3; k = k + 1)
            begin
                q[k] <= 56'h0;
            end
        end
        else
        begin
            // drain one word per accepted cycle
            if (word_valid && word_ready)
            begin
                q[0] <= q[1];
                q[1] <= q[2];
                qn <= qn - 2'd1;
            end
            if (reinit)
            begin
                // restart: drop pending samples
                pc <= 2'd0;
                fresh <= 1'b1;
                rcnt <= 5'd0;
            end
            else if (sample_valid && flush)
            begin
                // pending samples go out in the same slot, oldest first
                if (pc == 2'd2)
                begin
                    q[0] <= {TAG_BASE + `TOFF_NCT2, h0};
                    q[1] <= {TAG_BASE + `TOFF_NCT1, h1};
                    q[2] <= {TAG_BASE + `TOFF_NC, sample};
                    qn <= 2'd3;
                end
                else if (pc == 2'd1)
                begin
                    q[0] <= {TAG_BASE + `TOFF_NCT1, h0};
                    q[1] <= {TAG_BASE + `TOFF_NC, sample};
                    qn <= 2'd2;
                end
                else
                begin
                    q[0] <= {TAG_BASE + `TOFF_NC, sample};
                    qn <= 2'd1;
                end
                ref_val <= sample;
                pc <= 2'd0;
                fresh <= 1'b0;
                rcnt <= 5'd0;
            end
            else if (sample_valid && !active)
            begin
                // no compression: every sample goes out plain at once
                q[0] <= {TAG_BASE + `TOFF_NC, sample};
                qn <= 2'd1;
                fresh <= 1'b1;
                pc <= 2'd0;
            end
            else if (sample_valid && fresh)
            begin
                // first event after enabling: plain word of this slot
                q[0] <= {TAG_BASE + `TOFF_NC, sample};
                qn <= 2'd1;
                ref_val <= sample;
                fresh <= 1'b0;
                rcnt <= 5'd0;
            end
            else if (sample_valid && pc != 2'd2)
            begin
                // fill the three-event window, output held back
                if (pc == 2'd0)
                begin
                    h0 <= sample;
                end
                else
                begin
                    h1 <= sample;
                end
                pc <= pc + 2'd1;
                rcnt <= rcnt + 5'd1;
            end
            else if (sample_valid)
            begin
                qn <= 2'd1;
                if (!due && trp_ok)
                begin
                    // diffs of i, i-1, i-2 in five bits each
                    q[0] <= {TAG_BASE + `TOFF_TRP, 3'b000, d5a[14:0], d5b[14:0], d5c[14:0]};
                    ref_val <= sample;
                    pc <= 2'd0;
                    rcnt <= rcnt + 5'd1;
                end
                else if (!due && dbl_ok)
                begin
                    // diffs of i-1, i-2 in eight bits each
                    q[0] <= {TAG_BASE + `TOFF_DBL, pack(h0, h1, 8), pack(ref_val, h0, 8)};
                    ref_val <= h1;
                    h0 <= sample;
                    pc <= 2'd1;
                    rcnt <= rcnt + 5'd1;
                end
                else
                begin
                    // steep slope or refresh due: plain data of i-2
                    q[0] <= {TAG_BASE + `TOFF_NCT2, h0};
                    ref_val <= h0;
                    h0 <= h1;
                    h1 <= sample;
                    rcnt <= 5'd0;
                end
            end
        end
    end

endmodule // comp_engine

// [verif/fifo_wm_top_sva.sv]
// port assertions of the sample queue
`timescale 1ns/1ps
`include "fifo_wm_regs.vh"
module fifo_wm_chk
(
    input wire clk,
    input wire arst_n,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire acc_valid,
    input wire gyr_valid,
    input wire cfg_change,
    input wire watermark_flag,
    input wire full_flag
);
    reg [7:0] lvl; // shadow of the watermark level
    reg [3:0] quiet; // cycles since the last request or event
    // track level writes and idle time
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lvl <= 8'h00;
            quiet <= 4'h0;
        end
        else
        begin
            if (wr && addr == `QC1_ADDR)
                lvl <= wdata;
            if (wr || rd || acc_valid || gyr_valid || cfg_change)
                quiet <= 4'h0;
            else if (quiet != 4'hf)
                quiet <= quiet + 4'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_tag_read;
        rd && addr == `OUT_TAG_ADDR;
    endsequence
    sequence s_stat_read;
        rd && addr == `QS2_ADDR;
    endsequence
    a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_tag_legal: assert property (s_tag_read |=> rdata inside {8'h00, 8'h10,
        [8'h01:8'h05], [8'h09:8'h0d]}) else $error("illegal word tag");
    a_wtm_bit: assert property (s_stat_read |=> rdata[7] == $past(watermark_flag))
        else $error("status watermark bit differs");
    a_full_bit: assert property (s_stat_read |=> rdata[6] == $past(full_flag))
        else $error("status full bit differs");
    a_level_zero: assert property (lvl == 8'h00 |=> watermark_flag)
        else $error("level zero without watermark flag");
    a_full_wtm: assert property (full_flag |-> ##[0:2] watermark_flag)
        else $error("full without watermark flag");
    a_full_falls: assert property ($fell(full_flag) |->
        $past(rd, 1) || $past(rd, 2) || $past(rd, 3) || $past(wr, 1) || $past(wr, 2))
        else $error("full flag fell with no read");
    a_flags_quiet: assert property (quiet > 4'h5 |->
        $stable(watermark_flag) && $stable(full_flag)) else $error("flag moved while idle");
    a_unmapped_read: assert property (rd && addr > `EFI_ADDR |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // fifo_wm_chk
bind fifo_wm_top fifo_wm_chk i_chk (.*);

// [verif/host_model.sv]
// host reading the sample queue over the register port
`timescale 1ns/1ps
`include "fifo_wm_regs.vh"
module host_model
(
    input wire clk,
    input wire [7:0] rdata,
    output reg [7:0] addr = 8'h00,
    output reg [7:0] wdata = 8'h00,
    output reg wr = 1'b0,
    output reg rd = 1'b0
);
    reg [47:0] last = 48'h0; // last plain sample kept for decoding
    reg [7:0] b; // one data byte
    integer n; // byte index
    // one-cycle write strobe
    task wr_reg(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    end
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task rd_reg(input [7:0] a, output [7:0] d);
    begin
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    end
    endtask
    // whole seven-byte word from the tag onwards
    task rd_word(output [7:0] tag, output [47:0] w);
    begin
        rd_reg(`OUT_TAG_ADDR, tag);
        for (n = 0; n < 6; n = n + 1)
        begin
            rd_reg(`OUT_DATA_BASE + n[7:0], b);
            w[8 * n +: 8] = b;
        end
        if (tag == `TAG_ACC_BASE || tag == `TAG_GYR_BASE) // keep plain value
            last = w;
    end
    endtask
endmodule // host_model

// [verif/fifo_watermark_and_compression_test.sv]
// self-checking bench of the sample queue
`timescale 1ns/1ps
`include "fifo_wm_regs.vh"
module fifo_watermark_and_compression_test;
    localparam [47:0] FLUSH_TAGS = 48'h090d100a0b09; // gyro tags of the runtime-disable run: plain, triple, marker, then the flushed slots
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg acc_valid = 1'b0;
    reg gyr_valid = 1'b0;
    reg cfg_change = 1'b0;
    reg [47:0] acc_sample = 48'h0;
    reg [47:0] gyr_sample = 48'h0;
    wire [7:0] addr, wdata, rdata;
    wire wr, rd, watermark_flag, full_flag;
    wire [7:0] flags = {6'h0, full_flag, watermark_flag};
    integer mismatches = 0;
    integer cmp_count = 0;
    integer i;
    integer k;
    reg [3:0] j;
    reg [7:0] t;
    reg [47:0] w;
    reg [24:0] rows [0:7]; // enable, x/y step, z step, expected second tag
    always #4 clk = ~clk;
    fifo_wm_top i_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .acc_valid(acc_valid), .acc_sample(acc_sample),
        .gyr_valid(gyr_valid), .gyr_sample(gyr_sample), .cfg_change(cfg_change),
        .watermark_flag(watermark_flag), .full_flag(full_flag));
    host_model i_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd));
    // sample n of a ramp, three axes {z,y,x}
    function [47:0] sv(input [7:0] dxy, input [7:0] dz, input [3:0] n);
        sv = {16'h1000 + n * dz, 16'h1000 + n * dxy, 16'h1000 + n * dxy};
    endfunction
    task chk_byte(input [7:0] got, input [7:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
        end
    end
    endtask
    task chk_data(input [47:0] got, input [47:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t data %h expected %h", $time, got, exp);
        end
    end
    endtask
    // one batch event, spaced as a slow batch rate
    task push(input g, input [47:0] v);
    begin
        @(posedge clk);
        cfg_change <= 1'b0;
        acc_valid <= !g;
        gyr_valid <= g;
        acc_sample <= v;
        gyr_sample <= v;
        @(posedge clk);
        acc_valid <= 1'b0;
        gyr_valid <= 1'b0;
        acc_sample <= ~v;
        gyr_sample <= ~v;
        repeat (4) @(posedge clk);
    end
    endtask
    // read words until the empty tag shows
    task drain;
    begin
        t = 8'hff;
        for (k = 0; k < 300 && t !== `TAG_EMPTY; k = k + 1)
            i_host.rd_word(t, w);
    end
    endtask
    task end_of_test;
    begin
        if (mismatches == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    // watchdog against a hang
    initial
    begin
        #200000;
        mismatches = mismatches + 1;
        end_of_test;
    end
    initial
    begin
        rows[0] = {1'b1, 8'h01, 8'h01, 8'h05};
        rows[1] = {1'b1, 8'h0f, 8'h0f, 8'h05};
        rows[2] = {1'b1, 8'h10, 8'h10, 8'h04};
        rows[3] = {1'b1, 8'h7f, 8'h7f, 8'h04};
        rows[4] = {1'b1, 8'h80, 8'h80, 8'h02};
        rows[5] = {1'b1, 8'h01, 8'hc8, 8'h02};
        rows[6] = {1'b1, 8'h32, 8'h01, 8'h04};
        rows[7] = {1'b0, 8'h01, 8'h01, 8'h01};
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        for (i = 0; i < 8; i = i + 1)
        begin
            i_host.wr_reg(`EFI_ADDR, 8'h01);
            i_host.wr_reg(`EFE_ADDR, {7'h0, rows[i][24]});
            i_host.wr_reg(`QC2_ADDR, 8'h0e);
            for (j = 1; j < 5; j = j + 1)
                push(1'b0, sv(rows[i][23:16], rows[i][15:8], j));
            i_host.rd_word(t, w);
            chk_byte(t, `TAG_ACC_BASE);
            chk_data(w, sv(rows[i][23:16], rows[i][15:8], 4'h1));
            i_host.rd_word(t, w);
            chk_byte(t, rows[i][7:0]);
            @(posedge clk) cfg_change <= 1'b1;
            push(1'b0, sv(rows[i][23:16], rows[i][15:8], 4'h5));
            i_host.rd_word(t, w);
            chk_byte(t, rows[i][24] ? `TAG_CFG : `TAG_ACC_BASE);
            i_host.wr_reg(`QC2_ADDR, 8'h00);
            i_host.wr_reg(`EFE_ADDR, 8'h00);
            push(1'b0, 48'h0);
            drain;
        end
        // runtime disable: marker, then pending slots
        i_host.wr_reg(`EFI_ADDR, 8'h01);
        i_host.wr_reg(`EFE_ADDR, 8'h01);
        i_host.wr_reg(`QC2_ADDR, 8'h02);
        for (j = 1; j < 7; j = j + 1)
            push(1'b1, sv(8'h01, 8'h01, j));
        i_host.wr_reg(`QC2_ADDR, 8'h00);
        push(1'b1, sv(8'h01, 8'h01, 4'h7));
        for (i = 0; i < 6; i = i + 1)
        begin
            i_host.rd_word(t, w);
            chk_byte(t, FLUSH_TAGS[8 * (5 - i) +: 8]);
            if (i == 1)
                chk_data({3'h0, w[44:0]}, 48'h010842108421);
        end
        chk_data(w, sv(8'h01, 8'h01, 4'h7));
        i_host.wr_reg(`EFE_ADDR, 8'h00);
        // capped depth of three words
        i_host.wr_reg(`QC1_ADDR, 8'h03);
        i_host.wr_reg(`QC2_ADDR, 8'h01);
        for (j = 1; j < 5; j = j + 1)
        begin
            push(1'b0, sv(8'h10, 8'h10, j));
            chk_byte(flags, (j > 4'h2) ? 8'h03 : 8'h00);
        end
        i_host.wr_reg(`QC2_ADDR, 8'h11);
        push(1'b0, sv(8'h10, 8'h10, 4'h5));
        i_host.rd_reg(`QS1_ADDR, t);
        chk_byte(t, 8'h03);
        for (j = 2; j < 5; j = j + 1)
        begin
            i_host.rd_word(t, w);
            chk_data(w, sv(8'h10, 8'h10, (j == 4'h4) ? 4'h5 : j));
        end
        chk_byte(flags, 8'h00);
        // physical depth without the stop bit
        i_host.wr_reg(`QC1_ADDR, 8'h80);
        i_host.wr_reg(`QC2_ADDR, 8'h00);
        i_host.wr_reg(8'h40, 8'hff);
        for (i = 0; i < 257; i = i + 1)
        begin
            push(1'b0, sv(8'h01, 8'h01, i[3:0]));
            if (i == 126 || i == 127)
                chk_byte(flags, {7'h0, i == 127});
        end
        chk_byte(flags, 8'h03);
        i_host.rd_reg(`QS2_ADDR, t);
        chk_byte(t, 8'hc1);
        i_host.rd_reg(`QC1_ADDR, t);
        chk_byte(t, 8'h80);
        i_host.rd_reg(8'h40, t);
        chk_byte(t, 8'h00);
        drain;
        // second reset in mid-run
        @(posedge clk) arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        i_host.rd_reg(`QC1_ADDR, t);
        chk_byte(t, `WTM_RST);
        i_host.rd_reg(`QS1_ADDR, t);
        chk_byte(t, 8'h00);
        end_of_test;
    end
endmodule // fifo_watermark_and_compression_test
